// ### adia_pkg.sv
// shared constants for the audio dsp interrupt aggregator
`default_nettype none
package adia_pkg;
    localparam int unsigned MAP_W = 16;
    localparam int unsigned GPIO_N = 17;
    localparam int unsigned GPIO_SEL_W = 5;
    // interrupt map positions
    localparam int unsigned POS_SWI_HI = 15;
    localparam int unsigned POS_SWI_LO = 14;
    localparam int unsigned POS_RSV_HI = 13;
    localparam int unsigned POS_RSV_LO = 12;
    localparam int unsigned POS_TMR2 = 11;
    localparam int unsigned POS_TMR1 = 10;
    localparam int unsigned POS_DMA = 9;
    localparam int unsigned POS_WDOG = 8;
    localparam int unsigned POS_STBY = 7;
    localparam int unsigned POS_I2C = 6;
    localparam int unsigned POS_AIF2 = 5;
    localparam int unsigned POS_AIF1 = 4;
    localparam int unsigned POS_UART = 3;
    localparam int unsigned POS_SPI = 2;
    localparam int unsigned POS_GPIO = 1;
    localparam int unsigned POS_IRQ = 0;
    // positions that can ever latch a pending bit
    localparam logic [15:0] INPUT_MASK = 16'h0ffe;
    localparam logic [15:0] PEND_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'hffff;
    localparam logic [15:0] EDGE_RST = 16'h0000;
    localparam logic [1:0] SWI_RST = 2'h0;
    localparam logic [4:0] GPIO_SEL_RST = 5'h00;
endpackage
`default_nettype wire

// ### adia_detect.sv
// per-input synchroniser and level/edge detector
`default_nettype none
module adia_detect (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic src,
    input wire logic edge_mode,
    output logic hit
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } adia_det_s;
    adia_det_s st_q;
    adia_det_s st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.s1 = src;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // edge mode reacts to a rising edge only, level mode to high level
    assign hit = edge_mode ? (st_q.s2 & ~st_q.s3) : st_q.s2;
endmodule
`default_nettype wire

// ### adia_aggregator.sv
// interrupt aggregator: latching, masking, wake-up and irq pin drive
//
// How it works
// - Each input is detected by level or by rising edge as its edge bit says.
// - Any enabled pending input raises a wake request, even in sleep.
// - The block drives the external interrupt pin from enabled pending bits.
// - Map positions 15 and 14 are software interrupts into the dsp core.
// - Timers, dma, watchdog, i2c, aifs, uart, spi sit at fixed positions.
// - Position 7 is fed from the external standby pin.
// - The active-low standby pin is inverted so position 7 is active high.
// - Position 1 is the cascaded gpio interrupt, taken as active low.
// - A select value chooses which gpio input forms the cascaded source.
// - Map position 0 mirrors the interrupt pin, reading 1 while the pin is asserted low.
`default_nettype none
module adia_aggregator (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tmr2_irq,
    input wire logic tmr1_irq,
    input wire logic dma_irq,
    input wire logic wdog_irq,
    input wire logic i2c_irq,
    input wire logic aif2_irq,
    input wire logic aif1_irq,
    input wire logic uart_irq,
    input wire logic spi_irq,
    input wire logic standby_n,
    input wire logic [16:0] gpio_in,
    input wire logic [4:0] gpio_sel,
    input wire logic [15:0] mask_wdata,
    input wire logic mask_we,
    input wire logic [15:0] edge_wdata,
    input wire logic edge_we,
    input wire logic [15:0] clr_wdata,
    input wire logic clr_we,
    input wire logic [1:0] swi_wdata,
    input wire logic swi_we,
    output logic [15:0] pend_rdata,
    output logic [15:0] map_rdata,
    output logic swi_hi,
    output logic swi_lo,
    output logic wake_req,
    output logic irq_n
);
    typedef struct packed {
        logic [15:0] pend;
        logic [15:0] mask;
        logic [15:0] edg;
        logic [1:0] swi;
        logic [4:0] sel;
        logic [15:0] pend_rd;
        logic [15:0] map_rd;
        logic wake;
        logic irq_n;
    } adia_state_s;

    adia_state_s st_q;
    adia_state_s st_d;
    logic [15:0] raw;
    logic [15:0] hit;
    logic gpio_casc_n;

    // selected gpio, still active low; out-of-range select reads inactive
    assign gpio_casc_n = (st_q.sel < 5'(adia_pkg::GPIO_N)) ?
        gpio_in[st_q.sel] : 1'b1;

    always_comb
    begin
        raw = '0;
        raw[adia_pkg::POS_TMR2] = tmr2_irq;
        raw[adia_pkg::POS_TMR1] = tmr1_irq;
        raw[adia_pkg::POS_DMA] = dma_irq;
        raw[adia_pkg::POS_WDOG] = wdog_irq;
        raw[adia_pkg::POS_STBY] = ~standby_n;
        raw[adia_pkg::POS_I2C] = i2c_irq;
        raw[adia_pkg::POS_AIF2] = aif2_irq;
        raw[adia_pkg::POS_AIF1] = aif1_irq;
        raw[adia_pkg::POS_UART] = uart_irq;
        raw[adia_pkg::POS_SPI] = spi_irq;
        raw[adia_pkg::POS_GPIO] = ~gpio_casc_n;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_det
            adia_detect u_det (
                .mclk(mclk),
                .rst_n(rst_n),
                .src(raw[gi]),
                .edge_mode(st_q.edg[gi]),
                .hit(hit[gi])
            );
        end
    endgenerate

    logic [15:0] pend_nx;
    logic any_en;

    always_comb
    begin
        st_d = st_q;
        pend_nx = st_q.pend;
        if (clr_we)
            pend_nx = pend_nx & ~clr_wdata;
        // set beats a same-cycle clear so no event is lost
        pend_nx = (pend_nx | hit) & adia_pkg::INPUT_MASK;
        st_d.pend = pend_nx;
        if (mask_we)
            st_d.mask = mask_wdata;
        if (edge_we)
            st_d.edg = edge_wdata;
        if (swi_we)
            st_d.swi = swi_wdata;
        st_d.sel = gpio_sel;
        any_en = |(pend_nx & ~st_d.mask);
        st_d.wake = any_en;
        st_d.irq_n = ~any_en;
        st_d.pend_rd = pend_nx;
        st_d.map_rd = pend_nx;
        st_d.map_rd[adia_pkg::POS_SWI_HI] = st_d.swi[1];
        st_d.map_rd[adia_pkg::POS_SWI_LO] = st_d.swi[0];
        st_d.map_rd[adia_pkg::POS_IRQ] = ~st_d.irq_n;
    end

    // wake and irq are registered here; they need no clock beyond mclk,
    // which the chip keeps running for this block while the core sleeps
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q.pend <= adia_pkg::PEND_RST;
            st_q.mask <= adia_pkg::MASK_RST;
            st_q.edg <= adia_pkg::EDGE_RST;
            st_q.swi <= adia_pkg::SWI_RST;
            st_q.sel <= adia_pkg::GPIO_SEL_RST;
            st_q.pend_rd <= '0;
            st_q.map_rd <= '0;
            st_q.wake <= 1'b0;
            st_q.irq_n <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    assign pend_rdata = st_q.pend_rd;
    assign map_rdata = st_q.map_rd;
    assign swi_hi = st_q.swi[1];
    assign swi_lo = st_q.swi[0];
    assign wake_req = st_q.wake;
    assign irq_n = st_q.irq_n;

    property p_irq_follow;
        @(posedge mclk) disable iff (!rst_n)
        (|(st_q.pend & ~st_q.mask)) |-> !irq_n;
    endproperty
    irq_pin_low_a: assert property (p_irq_follow)
        else $error("irq pin high while enabled pending bit set");

    irq_idle_high_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !(|(st_q.pend & ~st_q.mask)) |-> irq_n)
        else $error("irq pin low with nothing pending");

    wake_match_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wake_req == !irq_n)
        else $error("wake request disagrees with irq pin");

    rsv_zero_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        pend_rdata[13:12] == 2'h0 && st_q.pend[13:12] == 2'h0)
        else $error("reserved position went pending");

    // spi position is the probe for the same-cycle clear race
    localparam int POS_T = 2;
    sequence s_hit_clr(int b);
        hit[b] && clr_we && clr_wdata[b];
    endsequence
    set_wins_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_hit_clr(POS_T) |=> st_q.pend[POS_T])
        else $error("event lost on same-cycle clear");

    clr_works_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (clr_we && clr_wdata[3] && !hit[3]) |=> !st_q.pend[3])
        else $error("pending bit not cleared");

    stby_pend_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (!standby_n && !st_q.edg[7] && !clr_we) [*4] |=> st_q.pend[7])
        else $error("standby low did not set position 7");

    swi_write_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        swi_we |=> (swi_hi == $past(swi_wdata[1])
            && swi_lo == $past(swi_wdata[0])))
        else $error("software interrupt not written");

    // three synchronised high samples must latch a level source
    sequence s_spi_level;
        (spi_irq && !st_q.edg[adia_pkg::POS_SPI]) [*3];
    endsequence
    // one low sample then three high ones make a rising edge
    sequence s_spi_rise;
        !spi_irq ##1 spi_irq [*2]
        ##1 (spi_irq && st_q.edg[adia_pkg::POS_SPI]);
    endsequence
    spi_level_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_spi_level |=> st_q.pend[adia_pkg::POS_SPI])
        else $error("level source did not latch");

    spi_edge_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_spi_rise |=> st_q.pend[adia_pkg::POS_SPI])
        else $error("rising edge did not latch");

    clr_all_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (clr_we && clr_wdata == 16'hffff && hit == 16'h0000)
        |=> pend_rdata == 16'h0000)
        else $error("full clear left a pending bit");

    map_swi_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        map_rdata[15:14] == {swi_hi, swi_lo})
        else $error("map does not show software interrupts");

    map_irq_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        map_rdata[adia_pkg::POS_IRQ] == !irq_n)
        else $error("map bit 0 disagrees with irq pin");
endmodule
`default_nettype wire

// ### adia_host_model.sv
// host model that watches the interrupt pin and counts requests
`default_nettype none
module adia_host_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic irq_n,
    output var int irq_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev_q;
    // only a falling pin edge is a new request; a held low is not re-counted
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_q <= 1'b1;
            irq_cnt <= 0;
        end
        else
        begin
            prev_q <= irq_n;
            if (prev_q && !irq_n)
                irq_cnt <= irq_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ### adia_aggregator_tb_top.sv
// self-checking bench for the interrupt aggregator
`default_nettype none
module adia_aggregator_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] src = 16'h0000;
    logic [16:0] gpio_lo = 17'h00000;
    logic [4:0] gpio_sel = 5'h00;
    logic [15:0] wd = 16'h0000;
    logic [3:0] we = 4'h0;
    logic [15:0] pend_rdata;
    logic [15:0] map_rdata;
    logic swi_hi;
    logic swi_lo;
    logic wake_req;
    logic irq_n;
    int irq_cnt;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    // each row: source vector in the top half, expected pending below
    logic [31:0] rows [11] = '{32'h08000800, 32'h04000400, 32'h02000200,
        32'h01000100, 32'h00800080, 32'h00400040, 32'h00200020,
        32'h00100010, 32'h00080008, 32'h00040004, 32'h00020002};
    adia_aggregator adia_aggregator_inst (.mclk(mclk), .rst_n(rst_n),
        .tmr2_irq(src[11]), .tmr1_irq(src[10]), .dma_irq(src[9]),
        .wdog_irq(src[8]), .i2c_irq(src[6]), .aif2_irq(src[5]),
        .aif1_irq(src[4]), .uart_irq(src[3]), .spi_irq(src[2]),
        .standby_n(~src[7]), .gpio_in(~({16'h0000, src[1]} | gpio_lo)),
        .gpio_sel(gpio_sel), .mask_wdata(wd), .mask_we(we[0]),
        .edge_wdata(wd), .edge_we(we[1]), .clr_wdata(wd), .clr_we(we[2]),
        .swi_wdata(wd[1:0]), .swi_we(we[3]), .pend_rdata(pend_rdata),
        .map_rdata(map_rdata), .swi_hi(swi_hi), .swi_lo(swi_lo),
        .wake_req(wake_req), .irq_n(irq_n));
    adia_host_model adia_host_model_inst (.mclk(mclk), .rst_n(rst_n),
        .irq_n(irq_n), .irq_cnt(irq_cnt));
    always #50 mclk = ~mclk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            conclude();
        end
    end
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk16({15'h0000, g}, {15'h0000, e});
    endtask
    // 0 mask, 1 edge, 2 clear, 3 software interrupt
    task automatic wr(input int k, input logic [15:0] d);
        @(posedge mclk);
        wd <= d;
        we <= 4'h1 << k;
        @(posedge mclk);
        we <= 4'h0;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic drive(input logic [15:0] s, input int n);
        @(posedge mclk);
        src <= s;
        w(n);
    endtask
    initial
    begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk1(irq_n, 1'b1);
        wr(0, 16'h0000);
        foreach (rows[i])
        begin
            drive(rows[i][31:16], 4);
            chk16(pend_rdata, rows[i][15:0]);
            chk16(map_rdata, rows[i][15:0] | 16'h0001);
            chk1(irq_n, 1'b0);
            chk1(wake_req, 1'b1);
            drive(16'h0000, 4);
            wr(2, 16'hffff);
            w(2);
            chk16(pend_rdata, 16'h0000);
            chk1(irq_n, 1'b1);
        end
        wr(0, 16'h0004);
        drive(16'h0004, 4);
        chk16(pend_rdata, 16'h0004);
        chk1(irq_n, 1'b1);
        chk1(wake_req, 1'b0);
        wr(0, 16'h0000);
        w(1);
        chk1(irq_n, 1'b0);
        // level mode re-latches while the source stays high
        wr(2, 16'h0004);
        w(2);
        chk16(pend_rdata, 16'h0004);
        drive(16'h0000, 4);
        wr(2, 16'hffff);
        wr(1, 16'h0004);
        drive(16'h0004, 4);
        chk16(pend_rdata, 16'h0004);
        wr(2, 16'h0004);
        w(3);
        chk16(pend_rdata, 16'h0000);
        drive(16'h0000, 4);
        wr(1, 16'h0000);
        gpio_sel <= 5'h10;
        gpio_lo <= 17'h00008;
        w(5);
        chk16(pend_rdata, 16'h0000);
        @(posedge mclk);
        gpio_sel <= 5'h03;
        w(5);
        chk16(pend_rdata, 16'h0002);
        @(posedge mclk);
        gpio_lo <= 17'h00000;
        w(4);
        wr(2, 16'hffff);
        wr(3, 16'h0002);
        w(1);
        chk1(swi_hi, 1'b1);
        chk1(swi_lo, 1'b0);
        wr(3, 16'h0001);
        w(1);
        chk16(map_rdata & 16'hc000, 16'h4000);
        // eleven rows, the unmask, the edge case and the cascade: 14 falls
        chk16(16'(irq_cnt), 16'h000e);
        @(posedge mclk);
        rst_n <= 1'b0;
        #1;
        chk1(swi_lo, 1'b0);
        chk1(irq_n, 1'b1);
        w(2);
        @(posedge mclk);
        rst_n <= 1'b1;
        w(2);
        chk16(map_rdata, 16'h0000);
        chk1(swi_hi, 1'b0);
        chk1(wake_req, 1'b0);
        // every position comes out of reset masked
        drive(16'h0800, 4);
        chk16(pend_rdata, 16'h0800);
        chk1(irq_n, 1'b1);
        chk1(wake_req, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
